//--- rtl/sir_pkg.sv
package sir_pkg;

  // register indices on the plain register port
  localparam logic [2:0] SIR_ADDR_CTRL = 3'h0;
  localparam logic [2:0] SIR_ADDR_MF0 = 3'h1;
  localparam logic [2:0] SIR_ADDR_MF1 = 3'h2;
  localparam logic [2:0] SIR_ADDR_GLB = 3'h3;
  localparam logic [2:0] SIR_ADDR_ISTAT = 3'h4;
  localparam logic [2:0] SIR_ADDR_IMASK = 3'h5;

  // secondary control register bit positions
  localparam int SIR_B_NV_F = 6;
  localparam int SIR_B_TICK_F = 5;
  localparam int SIR_B_CNT_F = 4; // event counter (timer variant) or two-wire (other)
  localparam int SIR_B_NV_E = 2;
  localparam int SIR_B_TICK_E = 1;
  localparam int SIR_B_CNT_E = 0;

  // multi-function register bit positions
  localparam int SIR_B_MF_HI_F = 5; // touch threshold / compare A
  localparam int SIR_B_MF_LO_F = 4; // touch overflow / compare P
  localparam int SIR_B_MF_HI_E = 1;
  localparam int SIR_B_MF_LO_E = 0;

  // implemented-bit masks
  localparam logic [7:0] SIR_MASK_CTRL_TMR = 8'h33;
  localparam logic [7:0] SIR_MASK_CTRL_NV = 8'h77;
  localparam logic [7:0] SIR_MASK_MF = 8'h33;
  localparam logic [7:0] SIR_MASK_GLB = 8'h01;
  localparam logic [7:0] SIR_MASK_IST = 8'h07;

  // block status event bits
  localparam int SIR_IS_SVC = 0;
  localparam int SIR_IS_HELD = 1;
  localparam int SIR_IS_MF = 2;

  localparam logic [7:0] SIR_RST_REG = 8'h00;
  localparam logic [4:0] SIR_RST_REQ = 5'h00;
  localparam logic [1:0] SIR_RST_MF = 2'h0;

  // variant select values
  localparam logic SIR_VAR_TIMER = 1'b0;
  localparam logic SIR_VAR_NV_TWI = 1'b1;

  // peripheral event pulses
  typedef struct packed {
    logic tick;
    logic cnt;
    logic nv;
    logic twi;
    logic th;
    logic ovf;
    logic cma;
    logic cmp;
  } sir_evt_t;

  // serviced source, one-hot
  typedef enum logic [3:0] {
    SIR_SVC_TICK = 4'h1,
    SIR_SVC_CNT = 4'h2,
    SIR_SVC_NV = 4'h4,
    SIR_SVC_TWI = 4'h8
  } sir_svc_t;

endpackage : sir_pkg

//--- rtl/sir_irq_regs.sv
`timescale 1ns/1ns
// How it works
// R1: unimplemented bits read zero; writes to them do nothing.
// R2: tick flag at bit 5, tick enable at bit 1, both variants.
// R3: timer variant: counter flag at bit 4, read/write, 1 pending.
// R4: timer variant: counter enable at bit 0, 1 lets it interrupt.
// R5: nv/two-wire variant: nv write-done flag at bit 6, 1 pending.
// R6: nv/two-wire variant: nv write-done enable at bit 2.
// R7: nv/two-wire variant: two-wire flag bit 4, enable bit 0.
// R8: touch register: threshold flag at bit 5, read/write.
// R9: touch register: count overflow flag at bit 4, read/write.
// R10: touch register: threshold enable at bit 1.
// R11: touch register: overflow enable at bit 0.
// R12: compare register: match A flag at bit 5, read/write.
// R13: compare register: match P flag at bit 4, read/write.
// R14: compare register: match A enable at bit 1.
// R15: compare register: match P enable at bit 0.
// R16: request needs own enable; global enable low blocks all of req_o (not mf_req_o), flags kept.
// R17: servicing a source clears its flag and the global enable.
// R18: multi register raises its request when any flag meets its enable.
// R19: all bits reset to zero; hardware set beats software write of zero.
module sir_irq_regs
  import sir_pkg::*;
#(
  parameter logic VARIANT = SIR_VAR_TIMER
) (
  input wire logic ref_clk_i, // system clock
  input wire logic srst_i, // synchronous reset, high
  input wire logic [2:0] addr_i, // register index
  input wire logic [7:0] wdata_i, // write data
  input wire logic we_i, // write strobe
  input wire logic re_i, // read strobe
  output logic [7:0] rdata_o, // read data, cycle after read
  input wire sir_evt_t evt_i, // peripheral event pulses
  input wire logic svc_i, // core services a vectored source
  input wire sir_svc_t svc_src_i, // which source is serviced
  output logic [4:0] req_o, // tick, cnt/twi, nv, mf0, mf1
  output logic [1:0] mf_req_o, // multi-function requests
  output logic gie_o, // global enable state
  output logic irq_o // block status interrupt
);

  localparam logic [7:0] CTRL_MASK =
    (VARIANT == SIR_VAR_NV_TWI) ? SIR_MASK_CTRL_NV : SIR_MASK_CTRL_TMR;

  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] mf0_q, mf0_d;
  logic [7:0] mf1_q, mf1_d;
  logic gie_q, gie_d;
  logic [7:0] ist_q, ist_d;
  logic [7:0] imk_q;
  logic [7:0] rdata_q;
  logic [4:0] req_q;
  logic [1:0] mf_q;
  logic irq_q;
  logic [7:0] ctrl_set, ctrl_clr, mf0_set, mf1_set, ist_set;
  logic [4:0] req_raw;
  logic [1:0] mf_raw;
  logic wr_ctrl, wr_mf0, wr_mf1, wr_glb, wr_ist, wr_imk;

  assign wr_ctrl = we_i && (addr_i == SIR_ADDR_CTRL);
  assign wr_mf0 = we_i && (addr_i == SIR_ADDR_MF0);
  assign wr_mf1 = we_i && (addr_i == SIR_ADDR_MF1);
  assign wr_glb = we_i && (addr_i == SIR_ADDR_GLB);
  assign wr_ist = we_i && (addr_i == SIR_ADDR_ISTAT);
  assign wr_imk = we_i && (addr_i == SIR_ADDR_IMASK);

  // hardware set and service clear vectors per variant
  always_comb begin
    ctrl_set = SIR_RST_REG;
    ctrl_clr = SIR_RST_REG;
    ctrl_set[SIR_B_TICK_F] = evt_i.tick; // [R2]
    ctrl_clr[SIR_B_TICK_F] = svc_i && (svc_src_i == SIR_SVC_TICK); // [R17]
    if (VARIANT == SIR_VAR_NV_TWI) begin
      ctrl_set[SIR_B_NV_F] = evt_i.nv; // [R5]
      ctrl_set[SIR_B_CNT_F] = evt_i.twi; // [R7]
      ctrl_clr[SIR_B_NV_F] = svc_i && (svc_src_i == SIR_SVC_NV); // [R17]
      ctrl_clr[SIR_B_CNT_F] = svc_i && (svc_src_i == SIR_SVC_TWI); // [R17]
    end else begin
      ctrl_set[SIR_B_CNT_F] = evt_i.cnt; // [R3]
      ctrl_clr[SIR_B_CNT_F] = svc_i && (svc_src_i == SIR_SVC_CNT); // [R17]
    end
    mf0_set = SIR_RST_REG;
    mf0_set[SIR_B_MF_HI_F] = evt_i.th; // [R8]
    mf0_set[SIR_B_MF_LO_F] = evt_i.ovf; // [R9]
    mf1_set = SIR_RST_REG;
    mf1_set[SIR_B_MF_HI_F] = evt_i.cma; // [R12]
    mf1_set[SIR_B_MF_LO_F] = evt_i.cmp; // [R13]
  end

  // set is or-ed in last so a pulse is never lost to a write or service
  always_comb begin
    ctrl_d = ((((wr_ctrl ? wdata_i : ctrl_q) & ~ctrl_clr)) | ctrl_set) & CTRL_MASK; // [R1] [R19]
    mf0_d = ((wr_mf0 ? wdata_i : mf0_q) | mf0_set) & SIR_MASK_MF; // [R1] [R19]
    mf1_d = ((wr_mf1 ? wdata_i : mf1_q) | mf1_set) & SIR_MASK_MF; // [R1] [R19]
  end

  // flag and enable storage
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ctrl_q <= SIR_RST_REG; // [R19]
      mf0_q <= SIR_RST_REG;
      mf1_q <= SIR_RST_REG;
    end else begin
      ctrl_q <= ctrl_d;
      mf0_q <= mf0_d;
      mf1_q <= mf1_d;
    end
  end

  // global enable: a service clears it even against a same-cycle write
  always_comb begin
    gie_d = wr_glb ? wdata_i[0] : gie_q;
    if (svc_i) begin
      gie_d = 1'b0; // [R17]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      gie_q <= 1'b0;
    end else begin
      gie_q <= gie_d;
    end
  end

  // multi-function requests ignore the global enable; the core gates them
  always_comb begin
    mf_raw[0] = |(mf0_q[SIR_B_MF_HI_F:SIR_B_MF_LO_F] & mf0_q[SIR_B_MF_HI_E:SIR_B_MF_LO_E]); // [R10] [R11] [R18]
    mf_raw[1] = |(mf1_q[SIR_B_MF_HI_F:SIR_B_MF_LO_F] & mf1_q[SIR_B_MF_HI_E:SIR_B_MF_LO_E]); // [R14] [R15] [R18]
  end

  // vectored requests need own enable and the global enable
  always_comb begin
    req_raw[0] = ctrl_q[SIR_B_TICK_F] & ctrl_q[SIR_B_TICK_E]; // [R2] [R16]
    req_raw[1] = ctrl_q[SIR_B_CNT_F] & ctrl_q[SIR_B_CNT_E]; // [R4] [R7] [R16]
    req_raw[2] = ctrl_q[SIR_B_NV_F] & ctrl_q[SIR_B_NV_E]; // [R6] [R16]
    req_raw[3] = mf_raw[0];
    req_raw[4] = mf_raw[1];
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      req_q <= SIR_RST_REQ;
      mf_q <= SIR_RST_MF;
    end else begin
      req_q <= gie_q ? req_raw : SIR_RST_REQ; // [R16]
      mf_q <= mf_raw; // [R18]
    end
  end

  // block status: service taken, request held off, multi request seen
  always_comb begin
    ist_set = SIR_RST_REG;
    ist_set[SIR_IS_SVC] = svc_i;
    ist_set[SIR_IS_HELD] = (|req_raw) && !gie_q;
    ist_set[SIR_IS_MF] = |mf_raw;
    ist_d = ((wr_ist ? (ist_q & ~wdata_i) : ist_q) | ist_set) & SIR_MASK_IST;
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ist_q <= SIR_RST_REG;
      imk_q <= SIR_RST_REG;
      irq_q <= 1'b0;
    end else begin
      ist_q <= ist_d;
      if (wr_imk) begin
        imk_q <= wdata_i & SIR_MASK_IST;
      end
      irq_q <= |(ist_q & imk_q);
    end
  end

  // read data stands only in the cycle after the strobe; unmapped read zero
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || !re_i) begin
      rdata_q <= SIR_RST_REG;
    end else begin
      case (addr_i)
        SIR_ADDR_CTRL: rdata_q <= ctrl_q; // [R1]
        SIR_ADDR_MF0: rdata_q <= mf0_q;
        SIR_ADDR_MF1: rdata_q <= mf1_q;
        SIR_ADDR_GLB: rdata_q <= {7'h00, gie_q};
        SIR_ADDR_ISTAT: rdata_q <= ist_q;
        SIR_ADDR_IMASK: rdata_q <= imk_q;
        default: rdata_q <= SIR_RST_REG;
      endcase
    end
  end

  assign rdata_o = rdata_q;
  assign req_o = req_q;
  assign mf_req_o = mf_q;
  assign gie_o = gie_q;
  assign irq_o = irq_q;

  a_tick_flag_set: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R2]
    evt_i.tick |=> ctrl_q[SIR_B_TICK_F])
    else $error("tick event did not set its flag");

  a_hw_set_wins: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R19]
    (evt_i.th && wr_mf0 && !wdata_i[SIR_B_MF_HI_F]) |=> mf0_q[SIR_B_MF_HI_F])
    else $error("write of zero beat a hardware set");

  a_svc_clears_gie: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R17]
    svc_i |=> !gie_q ##1 !req_o[0])
    else $error("service left global enable set");

  a_svc_clears_tick: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R17]
    (svc_i && svc_src_i == SIR_SVC_TICK && !evt_i.tick) |=> !ctrl_q[SIR_B_TICK_F])
    else $error("tick flag not cleared by service");

  a_req_gated: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R16]
    req_o[0] |-> $past(gie_q && ctrl_q[SIR_B_TICK_F] && ctrl_q[SIR_B_TICK_E]))
    else $error("tick request without enable");

  a_mf_req_match: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R18]
    (mf0_q[SIR_B_MF_LO_F] && mf0_q[SIR_B_MF_LO_E]) |=> mf_req_o[0])
    else $error("touch multi request missing");

  a_unimpl_zero: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R1]
    (re_i && addr_i == SIR_ADDR_MF1) |=> (rdata_o & ~SIR_MASK_MF) == 8'h00)
    else $error("unimplemented bits read nonzero");

  a_rd_one_cycle: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R1]
    !re_i |=> rdata_o == 8'h00)
    else $error("read data outside its cycle");

  a_irq_follows: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (|(ist_q & imk_q)) |=> irq_o)
    else $error("interrupt output missed status");

  // per-field checks; variant-specific ones are dead in the other variant
  a_ctrl_unimpl: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R1]
    (ctrl_q & ~CTRL_MASK) == 8'h00)
    else $error("control register holds an unimplemented bit");

  a_mf0_unimpl: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R1]
    (mf0_q & ~SIR_MASK_MF) == 8'h00)
    else $error("touch register holds an unimplemented bit");

  a_mf1_unimpl: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R1]
    (mf1_q & ~SIR_MASK_MF) == 8'h00)
    else $error("compare register holds an unimplemented bit");

  a_tick_flag_wr: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R2]
    (wr_ctrl && !evt_i.tick && !svc_i) |=> ctrl_q[SIR_B_TICK_F] == $past(wdata_i[SIR_B_TICK_F]))
    else $error("tick flag did not take the written value");

  a_tick_en_wr: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R2]
    wr_ctrl |=> ctrl_q[SIR_B_TICK_E] == $past(wdata_i[SIR_B_TICK_E]))
    else $error("tick enable did not take the written value");

  a_cnt_flag_set: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R3]
    (VARIANT == SIR_VAR_TIMER && evt_i.cnt) |=> ctrl_q[SIR_B_CNT_F])
    else $error("counter event did not set its flag");

  a_cnt_en_wr: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R4]
    wr_ctrl |=> ctrl_q[SIR_B_CNT_E] == $past(wdata_i[SIR_B_CNT_E]))
    else $error("bit 0 enable did not take the written value");

  a_cnt_req: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R4]
    (gie_q && ctrl_q[SIR_B_CNT_F] && ctrl_q[SIR_B_CNT_E]) |=> req_o[1])
    else $error("enabled bit 4 flag raised no request");

  a_nv_flag_set: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R5]
    (VARIANT == SIR_VAR_NV_TWI && evt_i.nv) |=> ctrl_q[SIR_B_NV_F])
    else $error("write-done event did not set its flag");

  a_nv_absent: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R5]
    (VARIANT == SIR_VAR_TIMER) |-> !ctrl_q[SIR_B_NV_F] && !ctrl_q[SIR_B_NV_E])
    else $error("timer variant holds write-done bits");

  a_nv_req: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R6]
    (gie_q && ctrl_q[SIR_B_NV_F] && ctrl_q[SIR_B_NV_E]) |=> req_o[2])
    else $error("enabled write-done flag raised no request");

  a_twi_flag_set: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R7]
    (VARIANT == SIR_VAR_NV_TWI && evt_i.twi) |=> ctrl_q[SIR_B_CNT_F])
    else $error("two-wire event did not set its flag");

  a_th_flag_set: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R8]
    evt_i.th |=> mf0_q[SIR_B_MF_HI_F])
    else $error("threshold event did not set its flag");

  a_ovf_flag_set: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R9]
    evt_i.ovf |=> mf0_q[SIR_B_MF_LO_F])
    else $error("overflow event did not set its flag");

  a_th_en_req: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R10]
    (mf0_q[SIR_B_MF_HI_F] && mf0_q[SIR_B_MF_HI_E]) |=> mf_req_o[0])
    else $error("enabled threshold flag raised no request");

  a_th_en_off: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R10]
    (!mf0_q[SIR_B_MF_HI_E] && !(mf0_q[SIR_B_MF_LO_F] && mf0_q[SIR_B_MF_LO_E]))
    |=> !mf_req_o[0])
    else $error("disabled threshold source raised a request");

  a_ovf_en_off: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R11]
    (!mf0_q[SIR_B_MF_LO_E] && !(mf0_q[SIR_B_MF_HI_F] && mf0_q[SIR_B_MF_HI_E]))
    |=> !mf_req_o[0])
    else $error("disabled overflow source raised a request");

  a_cma_flag_set: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R12]
    evt_i.cma |=> mf1_q[SIR_B_MF_HI_F])
    else $error("match A event did not set its flag");

  a_cmp_flag_set: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R13]
    evt_i.cmp |=> mf1_q[SIR_B_MF_LO_F])
    else $error("match P event did not set its flag");

  a_cma_en_req: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R14]
    (mf1_q[SIR_B_MF_HI_F] && mf1_q[SIR_B_MF_HI_E]) |=> mf_req_o[1])
    else $error("enabled match A flag raised no request");

  a_cmp_en_req: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R15]
    (mf1_q[SIR_B_MF_LO_F] && mf1_q[SIR_B_MF_LO_E]) |=> mf_req_o[1])
    else $error("enabled match P flag raised no request");

  a_gie_blocks: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R16]
    !gie_q |=> req_o == SIR_RST_REQ)
    else $error("request passed with global enable low");

  a_no_en_no_req: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R16]
    !ctrl_q[SIR_B_TICK_E] |=> !req_o[0])
    else $error("tick request without its own enable");

  a_svc_clr_cnt: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R17]
    (VARIANT == SIR_VAR_TIMER && svc_i && svc_src_i == SIR_SVC_CNT && !evt_i.cnt)
    |=> !ctrl_q[SIR_B_CNT_F])
    else $error("counter flag not cleared by service");

  a_svc_clr_nv: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R17]
    (VARIANT == SIR_VAR_NV_TWI && svc_i && svc_src_i == SIR_SVC_NV && !evt_i.nv)
    |=> !ctrl_q[SIR_B_NV_F])
    else $error("write-done flag not cleared by service");

  a_svc_clr_twi: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R17]
    (VARIANT == SIR_VAR_NV_TWI && svc_i && svc_src_i == SIR_SVC_TWI && !evt_i.twi)
    |=> !ctrl_q[SIR_B_CNT_F])
    else $error("two-wire flag not cleared by service");

  a_mf1_req_off: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R18]
    !(|(mf1_q[SIR_B_MF_HI_F:SIR_B_MF_LO_F] & mf1_q[SIR_B_MF_HI_E:SIR_B_MF_LO_E]))
    |=> !mf_req_o[1])
    else $error("compare multi request without an enabled flag");

  // no disable here: the check is about what reset itself leaves behind
  a_rst_zero: assert property (@(posedge ref_clk_i) // [R19]
    srst_i |=> ctrl_q == SIR_RST_REG && mf0_q == SIR_RST_REG && mf1_q == SIR_RST_REG && !gie_q)
    else $error("register not zero after reset");

  a_hw_set_tick: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R19]
    (evt_i.tick && wr_ctrl) |=> ctrl_q[SIR_B_TICK_F])
    else $error("write beat a hardware tick set");

endmodule : sir_irq_regs

//--- sim/sir_core_model.sv
`timescale 1ns/1ns
// far side: peripherals pulse events and the core acknowledges service;
// commands are registered so each pulse starts cleanly on a clock edge and lasts as long as its command
module sir_core_model
  import sir_pkg::*;
(
  input wire logic ref_clk_i, // system clock
  input wire sir_evt_t evt_cmd_i, // events to raise
  input wire logic svc_cmd_i, // service to signal
  input wire sir_svc_t src_cmd_i, // serviced source
  output sir_evt_t evt_o, // event pulses
  output logic svc_o, // service pulse
  output sir_svc_t svc_src_o // serviced source, valid with svc_o
);
  // launch on the edge after the command, like a real peripheral flop
  always_ff @(posedge ref_clk_i) begin
    evt_o <= evt_cmd_i;
    svc_o <= svc_cmd_i;
    svc_src_o <= src_cmd_i;
  end
endmodule : sir_core_model

//--- sim/sir_irq_regs_test.sv
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module sir_irq_regs_test
  import sir_pkg::*;
;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic we = 1'b0;
  logic re = 1'b0;
  logic svc_cmd = 1'b0;
  sir_svc_t src_cmd = SIR_SVC_TICK;
  sir_evt_t evt_cmd = 8'h00;
  sir_evt_t evt;
  logic svc;
  sir_svc_t svc_src;
  logic [7:0] rdata0, rdata1, rd0, rd1;
  logic [4:0] req0;
  logic [1:0] mfq0;
  logic gie0, irq0;
  int n_fail = 0;
  int num_checks = 0;

  sir_core_model core (.ref_clk_i(ref_clk), .evt_cmd_i(evt_cmd), .svc_cmd_i(svc_cmd),
    .src_cmd_i(src_cmd), .evt_o(evt), .svc_o(svc), .svc_src_o(svc_src));
  // both variants share one bus so each access reaches the two layouts
  sir_irq_regs #(.VARIANT(SIR_VAR_TIMER)) DUT (.ref_clk_i(ref_clk), .srst_i(srst),
    .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata0), .evt_i(evt),
    .svc_i(svc), .svc_src_i(svc_src), .req_o(req0), .mf_req_o(mfq0), .gie_o(gie0),
    .irq_o(irq0));
  sir_irq_regs #(.VARIANT(SIR_VAR_NV_TWI)) DUT1 (.ref_clk_i(ref_clk), .srst_i(srst),
    .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata1), .evt_i(evt),
    .svc_i(svc), .svc_src_i(svc_src), .req_o(), .mf_req_o(), .gie_o(), .irq_o());

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // a leading edge keeps strobes from being driven twice in one step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    we <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(posedge ref_clk);
    re <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    re <= 1'b0;
    #1;
    rd0 = rdata0;
    rd1 = rdata1;
  endtask : rd

  // flag lands one cycle after the event, request one more
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic pulse_evt(input sir_evt_t e);
    @(posedge ref_clk);
    evt_cmd <= e;
    @(posedge ref_clk);
    evt_cmd <= 8'h00;
    settle();
  endtask : pulse_evt

  task automatic svc_pulse(input sir_svc_t s);
    @(posedge ref_clk);
    svc_cmd <= 1'b1;
    src_cmd <= s;
    @(posedge ref_clk);
    svc_cmd <= 1'b0;
    settle();
  endtask : svc_pulse

  task automatic s_reset;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a));
      `CHK({rd0, rd1}, 16'h0000)
    end
  endtask : s_reset

  task automatic s_fields;
    wr(SIR_ADDR_CTRL, 8'hff);
    rd(SIR_ADDR_CTRL);
    `CHK(rd0, 8'h33)
    `CHK(rd1, 8'h77)
    for (int a = 1; a < 3; a++) begin
      wr(3'(a), 8'hff);
      rd(3'(a));
      `CHK({rd0, rd1}, 16'h3333)
      wr(3'(a), 8'h00);
    end
    wr(SIR_ADDR_CTRL, 8'h00);
  endtask : s_fields

  // every event with all enables low, then one enable, then global
  task automatic s_events;
    pulse_evt(8'hff);
    rd(SIR_ADDR_CTRL);
    `CHK(rd0, 8'h30)
    `CHK(rd1, 8'h70)
    rd(SIR_ADDR_MF0);
    `CHK({rd0, rd1}, 16'h3030)
    rd(SIR_ADDR_MF1);
    `CHK({rd0, rd1}, 16'h3030)
    `CHK({req0, mfq0}, 7'h00)
    wr(SIR_ADDR_MF1, 8'h32);
    settle();
    `CHK({req0, mfq0}, 7'h02)
    wr(SIR_ADDR_GLB, 8'h01);
    settle();
    `CHK({gie0, req0}, 6'h30)
  endtask : s_events

  task automatic s_service;
    wr(SIR_ADDR_ISTAT, 8'h07);
    wr(SIR_ADDR_CTRL, 8'h32);
    settle();
    `CHK(req0, 5'h11)
    svc_pulse(SIR_SVC_TICK);
    rd(SIR_ADDR_CTRL);
    `CHK({gie0, req0, rd0}, 14'h0012)
    rd(SIR_ADDR_ISTAT);
    `CHK(rd0 & 8'h01, 8'h01)
  endtask : s_service

  // status bit raises the line only while its mask bit is set
  task automatic s_irq;
    `CHK(irq0, 1'b0)
    wr(SIR_ADDR_IMASK, 8'h01);
    settle();
    `CHK(irq0, 1'b1)
    wr(SIR_ADDR_ISTAT, 8'h01);
    settle();
    `CHK(irq0, 1'b0)
  endtask : s_irq

  // tick event reaches the bank on the same edge as a write of zero
  task automatic s_hw_wins;
    @(posedge ref_clk);
    evt_cmd <= 8'h80;
    @(posedge ref_clk);
    evt_cmd <= 8'h00;
    we <= 1'b1;
    addr <= SIR_ADDR_CTRL;
    wdata <= 8'h00;
    @(posedge ref_clk);
    we <= 1'b0;
    settle();
    rd(SIR_ADDR_CTRL);
    `CHK(rd0, 8'h20)
    @(posedge ref_clk);
    evt_cmd <= 8'h08;
    @(posedge ref_clk);
    evt_cmd <= 8'h00;
    we <= 1'b1;
    addr <= SIR_ADDR_MF0;
    wdata <= 8'h00;
    @(posedge ref_clk);
    we <= 1'b0;
    settle();
    rd(SIR_ADDR_MF0);
    `CHK({rd0, rd1}, 16'h2020)
  endtask : s_hw_wins

  // each non-tick source is serviced in turn; only its own variant reacts
  task automatic s_svc_src;
    pulse_evt(8'hff);
    svc_pulse(SIR_SVC_CNT);
    rd(SIR_ADDR_CTRL);
    `CHK({rd0, rd1}, 16'h2070)
    svc_pulse(SIR_SVC_NV);
    rd(SIR_ADDR_CTRL);
    `CHK({rd0, rd1}, 16'h2030)
    svc_pulse(SIR_SVC_TWI);
    rd(SIR_ADDR_CTRL);
    `CHK({rd0, rd1}, 16'h2020)
  endtask : s_svc_src

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    s_reset();
    s_fields();
    s_events();
    s_service();
    s_irq();
    s_hw_wins();
    s_svc_src();
    tally_and_finish();
  end
endmodule : sir_irq_regs_test
